/* include/saosp_pkg.sv */
/*
 * Shared constants and types for the serial result output port of a
 * 16-bit successive-approximation converter and its host controller.
 * Assumes a 100 MHz system clock on both ends.
 */
package saosp_pkg;

    // ========================================================================
    // Word layout
    localparam int RESULT_W = 16;
    localparam logic [15:0] CODE_POS_FS = 16'h7fff;
    localparam logic [15:0] CODE_NEG_FS = 16'h8000;
    localparam logic [15:0] RESULT_RST  = 16'h0000;

    // ========================================================================
    // Timing
    localparam int CLK_MHZ         = 100;
    localparam int INT_CLK_KHZ     = 900;
    localparam int INT_HALF_CYC    = (CLK_MHZ * 1000) / (2 * INT_CLK_KHZ);
    localparam int PREV_VALID_US   = 12;
    localparam int PREV_VALID_CYC  = PREV_VALID_US * CLK_MHZ;
    localparam int CONV_US         = 20;
    localparam int CONV_CYC        = CONV_US * CLK_MHZ;
    localparam int EXT_CLK_MAX_MHZ = 10;
    localparam int EXT_MIN_PER_CYC = CLK_MHZ / EXT_CLK_MAX_MHZ;
    localparam int EXT_HIGH_PCT    = 50;
    localparam int EXT_HALF_CYC    = (EXT_MIN_PER_CYC * 4 * EXT_HIGH_PCT) / 100;

    // ========================================================================
    // Device state
    typedef enum logic [1:0] {
        SAOSP_IDLE,
        SAOSP_CONV,
        SAOSP_DONE
    } saosp_conv_e;

endpackage

/* include/saosp_if.sv */
/*
 * Pin-level carrier between the converter end and the host end.
 * Assumes both ends run on the same bench clock; pins are plain levels.
 */
interface saosp_if;
    logic chip_select_n;
    logic read_not_convert;
    logic clock_source_select;
    logic busy_n;
    logic serial_out_line;
    logic chain_in;
    logic clk_host_out;
    logic clk_host_oe;
    logic clk_dev_out;
    logic clk_dev_oe;
    logic parallel_oe;
    logic serial_bit_clock;

    // The bit clock pin is driven by whichever end enables it.
    assign serial_bit_clock = clk_host_oe ? clk_host_out :
                              clk_dev_oe  ? clk_dev_out  : 1'b0;

    modport device (
        input  chip_select_n, read_not_convert, clock_source_select,
        input  chain_in, serial_bit_clock,
        output busy_n, serial_out_line, clk_dev_out, clk_dev_oe, parallel_oe
    );
    modport host (
        output chip_select_n, read_not_convert, clock_source_select,
        output chain_in, clk_host_out, clk_host_oe,
        input  busy_n, serial_out_line, serial_bit_clock
    );
endinterface

/* core/saosp_fifo.sv */
/*
 * Small flip-flop FIFO with valid/ready on both sides.
 * Assumes one clock; the drain side may stall at will.
 */
module saosp_fifo #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 32
) (
    // Clock and reset
    input  wire logic             clk,
    input  wire logic             rst_n,
    input  wire logic             ce,
    // Fill side
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    // Drain side
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic [WIDTH-1:0]      out_data
);
    localparam int AW = $clog2(DEPTH);

    initial begin
        if (DEPTH < 2 || (1 << AW) != DEPTH) $error("DEPTH must be a power of two");
    end

    logic [WIDTH-1:0] mem_reg [DEPTH];
    logic [AW:0]      wr_reg;
    logic [AW:0]      rd_reg;
    logic             push;
    logic             pop;

    // ========================================================================
    // Flags
    assign in_ready  = (wr_reg - rd_reg) != (AW+1)'(DEPTH);
    assign out_valid = wr_reg != rd_reg;
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;
    assign out_data  = mem_reg[rd_reg[AW-1:0]];

    // Storage is not reset; only pointers carry state.
    always_ff @(posedge clk) begin
        if (ce && push) begin
            mem_reg[wr_reg[AW-1:0]] <= in_data;
        end
    end

    // Pointers.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wr_reg <= '0;
            rd_reg <= '0;
        end else if (ce) begin
            if (push) wr_reg <= wr_reg + 1'b1;
            if (pop)  rd_reg <= rd_reg + 1'b1;
        end
    end
endmodule

/* core/saosp_device.sv */
/*
 * Converter end: conversion sequencer, clipping, output shift register,
 * internal burst bit clock and external-clock shifting with chain input.
 * Assumes host pins arrive asynchronously and are synchronised here.
 */
//
// Contract
// - Parallel outputs enabled when selected and reading.
// - Serial output is always driven.
// - Clock source select picks internal or external.
// - Select plus convert low starts conversion and burst.
// - Internal mode shifts previous result MSB first.
// - Bits stable across both edges of pulse.
// - After sixteen pulses clock low, chain bit out.
// - External clock only shifts, never converts.
// - Host holds select low, read high to shift.
// - External clock at most 10MHz, 20-70% high.
// - Load after 12us; lost if reading with clock high.
// - Host keeps read or clock low during load.
// - Busy rises only after result is loaded.
// - External bit k valid k-th fall, (k+1)-th rise.
// - Chain bits follow LSB one pulse each.
// - Chain data passes until next reload.
// - Previous result readable 12us into conversion.
// - Host does not clock during load window.
// - Host avoids clocking during conversion.
// - Out-of-range inputs clamp to full scale.
module saosp_device
    import saosp_pkg::*;
#(
    parameter int CONV_CYCLES = saosp_pkg::CONV_CYC,
    parameter int LOAD_CYCLES = saosp_pkg::PREV_VALID_CYC
) (
    // Clock, reset, enable
    input  wire logic                         CLK,
    input  wire logic                         RST_N,
    input  wire logic                         CE,
    // Pins
    saosp_if.device                           PINS,
    // Analog sample stand-in, signed and wider than the code
    input  wire logic signed [RESULT_W+1:0]   SAMPLE_IN,
    // Status
    output logic [RESULT_W-1:0]               LAST_RESULT
);
    import saosp_pkg::*;

    initial begin
        if (LOAD_CYCLES >= CONV_CYCLES) $error("load must fall inside conversion");
        if (2 * RESULT_W * INT_HALF_CYC >= CONV_CYCLES) $error("burst must end before load");
    end

    // Clamp a wide signed sample into the 16-bit code without wrapping.
    function automatic logic [RESULT_W-1:0] clip(input logic signed [RESULT_W+1:0] s);
        if (s > $signed({2'b00, CODE_POS_FS}))      return CODE_POS_FS;
        else if (s < $signed({2'b11, CODE_NEG_FS})) return CODE_NEG_FS;
        else                                        return s[RESULT_W-1:0];
    endfunction

    // ========================================================================
    // Pin synchronisers
    logic [1:0] cs_sync;
    logic [1:0] rc_sync;
    logic [1:0] src_sync;
    logic [1:0] bclk_sync;
    logic [1:0] tag_sync;
    logic       bclk_d_reg;
    logic       cs_n;
    logic       rc;
    logic       ext_mode;
    logic       bclk;
    logic       tag;

    // Two flops on every host pin.
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            cs_sync   <= 2'h3;
            rc_sync   <= 2'h3;
            src_sync  <= 2'h0;
            bclk_sync <= 2'h0;
            tag_sync  <= 2'h0;
        end else if (CE) begin
            cs_sync   <= {cs_sync[0], PINS.chip_select_n};
            rc_sync   <= {rc_sync[0], PINS.read_not_convert};
            src_sync  <= {src_sync[0], PINS.clock_source_select};
            bclk_sync <= {bclk_sync[0], PINS.serial_bit_clock};
            tag_sync  <= {tag_sync[0], PINS.chain_in};
        end
    end

    assign cs_n     = cs_sync[1];
    assign rc       = rc_sync[1];
    assign ext_mode = src_sync[1];
    assign bclk     = bclk_sync[1];
    assign tag      = tag_sync[1];

    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) bclk_d_reg <= 1'b0;
        else if (CE) bclk_d_reg <= bclk;
    end

    // ========================================================================
    // Conversion sequencer
    saosp_conv_e      state_reg;
    logic [15:0]      conv_cnt_reg;
    logic             start;
    logic             load;
    logic             busy_n_reg;
    logic             rc_d_reg;
    logic [RESULT_W:0]   shift_reg;
    logic [RESULT_W-1:0] code;
    logic             ext_rise;
    logic             ext_fall;
    logic             reading;

    // A conversion starts on a falling read/convert with select low.
    assign start    = !cs_n && !rc && rc_d_reg && state_reg == SAOSP_IDLE;
    // The word is taken in the last conversion cycle, after any burst has ended,
    // so a burst never sees its register reloaded in mid-word.
    assign load     = state_reg == SAOSP_CONV && conv_cnt_reg == 16'(CONV_CYCLES - 1);
    assign code     = clip(SAMPLE_IN);
    assign reading  = !cs_n && rc && ext_mode;
    assign ext_rise = reading && bclk && !bclk_d_reg;
    assign ext_fall = reading && !bclk && bclk_d_reg;

    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) rc_d_reg <= 1'b1;
        else if (CE) rc_d_reg <= rc;
    end

    // The external clock never feeds this sequencer.
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            state_reg    <= SAOSP_IDLE;
            conv_cnt_reg <= '0;
            busy_n_reg   <= 1'b1;
        end else if (CE) begin
            unique case (state_reg)
                SAOSP_IDLE: begin
                    if (start) begin
                        state_reg    <= SAOSP_CONV;
                        conv_cnt_reg <= '0;
                        busy_n_reg   <= 1'b0;
                    end
                end
                SAOSP_CONV: begin
                    conv_cnt_reg <= conv_cnt_reg + 16'h0001;
                    if (conv_cnt_reg == 16'(CONV_CYCLES - 1)) state_reg <= SAOSP_DONE;
                end
                SAOSP_DONE: begin
                    busy_n_reg <= 1'b1;
                    state_reg  <= SAOSP_IDLE;
                end
            endcase
        end
    end

    // Result register, captured at the load instant.
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) LAST_RESULT <= RESULT_RST;
        else if (CE && load) LAST_RESULT <= code;
    end

    // ========================================================================
    // Internal burst clock
    logic [7:0] half_cnt_reg;
    logic [5:0] edge_cnt_reg;
    logic       iclk_reg;
    logic       burst;
    logic       tag_first_reg;

    assign burst = !ext_mode && edge_cnt_reg != 6'h00;

    // Sixteen pulses are thirty-two half periods; the burst ends low.
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            half_cnt_reg <= '0;
            edge_cnt_reg <= '0;
            iclk_reg     <= 1'b0;
        end else if (CE) begin
            if (start && !ext_mode) begin
                edge_cnt_reg <= 6'(2 * RESULT_W);
                half_cnt_reg <= '0;
                iclk_reg     <= 1'b0;
            end else if (burst) begin
                if (half_cnt_reg == 8'(INT_HALF_CYC - 1)) begin
                    half_cnt_reg <= '0;
                    iclk_reg     <= !iclk_reg;
                    edge_cnt_reg <= edge_cnt_reg - 6'h01;
                end else begin
                    half_cnt_reg <= half_cnt_reg + 8'h01;
                end
            end else begin
                iclk_reg <= 1'b0;
            end
        end
    end

    // ========================================================================
    // Output shift register
    logic burst_shift;

    // Shift on each falling internal edge so data spans both edges of a pulse.
    assign burst_shift = burst && iclk_reg && half_cnt_reg == 8'(INT_HALF_CYC - 1);

    // A lead copy of the MSB sits above the word: the first external rising
    // edge drops it, so every later rising edge moves on by one bit. A burst
    // drops it at its start instead.
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            shift_reg     <= {1'b0, RESULT_RST};
            tag_first_reg <= 1'b0;
        end else if (CE) begin
            if (load && !(reading && bclk)) begin
                shift_reg <= {code[RESULT_W-1], code};
            end else if (start && !ext_mode) begin
                shift_reg <= {shift_reg[RESULT_W-1:0], 1'b0};
            end else if (burst_shift) begin
                if (edge_cnt_reg == 6'h1f) tag_first_reg <= tag;
                shift_reg <= edge_cnt_reg == 6'h01 ?
                             {(RESULT_W+1){tag_first_reg}} : {shift_reg[RESULT_W-1:0], 1'b0};
            end else if (ext_rise && !(state_reg == SAOSP_CONV &&
                                       conv_cnt_reg >= 16'(LOAD_CYCLES))) begin
                shift_reg <= {shift_reg[RESULT_W-1:0], tag};
            end
        end
    end

    // ========================================================================
    // Pin drives
    assign PINS.serial_out_line = shift_reg[RESULT_W];
    assign PINS.busy_n          = busy_n_reg;
    assign PINS.clk_dev_out     = iclk_reg;
    assign PINS.clk_dev_oe      = !ext_mode;
    assign PINS.parallel_oe     = !cs_n && rc;
endmodule

/* core/saosp_host.sv */
/*
 * Host end: starts conversions, drives the external bit clock in
 * external mode, and in that mode collects 16-bit results into a FIFO.
 * Assumes device pins arrive asynchronously and are synchronised here.
 */
module saosp_host
    import saosp_pkg::*;
(
    // Clock, reset, enable
    input  wire logic                CLK,
    input  wire logic                RST_N,
    input  wire logic                CE,
    // Pins
    saosp_if.host                    PINS,
    // User side
    input  wire logic                EXT_MODE,
    input  wire logic                CHAIN_BIT,
    input  wire logic                START,
    output logic                     START_READY,
    output logic                     WORD_VALID,
    input  wire logic                WORD_READY,
    output logic [RESULT_W-1:0]      WORD_DATA
);
    import saosp_pkg::*;

    typedef enum logic [2:0] {
        SAOSP_H_IDLE, SAOSP_H_CONV, SAOSP_H_WAIT, SAOSP_H_READ, SAOSP_H_PUSH
    } saosp_host_e;

    saosp_host_e         st_reg;
    logic [1:0]          busy_sync;
    logic [1:0]          sd_sync;
    logic [7:0]          div_reg;
    logic [4:0]          bit_reg;
    logic                clk_reg;
    logic [RESULT_W-1:0] word_reg;
    logic                fifo_ready;

    // Device pins pass two flops.
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            busy_sync <= 2'h3;
            sd_sync   <= 2'h0;
        end else if (CE) begin
            busy_sync <= {busy_sync[0], PINS.busy_n};
            sd_sync   <= {sd_sync[0], PINS.serial_out_line};
        end
    end

    assign START_READY = st_reg == SAOSP_H_IDLE && fifo_ready;

    // Convert, wait for busy, then clock out only after busy rises.
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            st_reg   <= SAOSP_H_IDLE;
            div_reg  <= '0;
            bit_reg  <= '0;
            clk_reg  <= 1'b0;
            word_reg <= RESULT_RST;
        end else if (CE) begin
            unique case (st_reg)
                SAOSP_H_IDLE: if (START && fifo_ready) st_reg <= SAOSP_H_CONV;
                SAOSP_H_CONV: if (!busy_sync[1]) st_reg <= SAOSP_H_WAIT;
                SAOSP_H_WAIT: if (busy_sync[1]) begin
                    // In internal mode the burst already carried the word out.
                    st_reg  <= EXT_MODE ? SAOSP_H_READ : SAOSP_H_IDLE;
                    bit_reg <= '0;
                    div_reg <= '0;
                end
                SAOSP_H_READ: begin
                    if (div_reg == 8'(EXT_HALF_CYC - 1)) begin
                        div_reg <= '0;
                        clk_reg <= !clk_reg;
                        if (clk_reg) begin
                            word_reg <= {word_reg[RESULT_W-2:0], sd_sync[1]};
                            bit_reg  <= bit_reg + 5'h01;
                            if (bit_reg == 5'(RESULT_W - 1)) st_reg <= SAOSP_H_PUSH;
                        end
                    end else begin
                        div_reg <= div_reg + 8'h01;
                    end
                end
                SAOSP_H_PUSH: st_reg <= SAOSP_H_IDLE;
                default:      st_reg <= SAOSP_H_IDLE;
            endcase
        end
    end

    // Read/convert low only while converting; clock low during the load window.
    assign PINS.chip_select_n       = 1'b0;
    assign PINS.read_not_convert    = st_reg != SAOSP_H_CONV;
    assign PINS.clock_source_select = EXT_MODE;
    assign PINS.chain_in            = CHAIN_BIT;
    assign PINS.clk_host_out        = clk_reg;
    assign PINS.clk_host_oe         = EXT_MODE;

    saosp_fifo #(.WIDTH(RESULT_W), .DEPTH(32)) u_fifo (
        .clk      (CLK),
        .rst_n    (RST_N),
        .ce       (CE),
        .in_valid (st_reg == SAOSP_H_PUSH),
        .in_ready (fifo_ready),
        .in_data  (word_reg),
        .out_valid(WORD_VALID),
        .out_ready(WORD_READY),
        .out_data (WORD_DATA)
    );
endmodule

/* testbench/saosp_assertions.sv */
/*
 * Concurrent checks on the pins between the converter end and the host end.
 * Assumes one clock domain and the interface signals wired in by name.
 */
module saosp_assertions
    import saosp_pkg::*;
#(
    parameter int CONV_CYCLES = saosp_pkg::CONV_CYC
) (
    // Clock and reset
    input wire logic CLK,
    input wire logic RST_N,
    // Pins
    input wire logic chip_select_n,
    input wire logic read_not_convert,
    input wire logic clock_source_select,
    input wire logic busy_n,
    input wire logic serial_out_line,
    input wire logic clk_dev_out,
    input wire logic clk_dev_oe,
    input wire logic parallel_oe,
    input wire logic serial_bit_clock
);
    timeunit 1ns;
    timeprecision 1ps;

    // ========================================================================
    // Helper counters
    logic [15:0] low_cnt_reg;
    logic [7:0]  hi_cnt_reg;
    logic [4:0]  pulse_cnt_reg;
    logic        dclk_prev_reg;

    default clocking dc @(posedge CLK); endclocking
    default disable iff (!RST_N);

    // Length of the present busy phase, zero while idle.
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) low_cnt_reg <= 16'h0000;
        else low_cnt_reg <= busy_n ? 16'h0000 : low_cnt_reg + 16'h0001;
    end

    // Length of the present high phase of the burst clock.
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) hi_cnt_reg <= 8'h00;
        else hi_cnt_reg <= clk_dev_out ? hi_cnt_reg + 8'h01 : 8'h00;
    end

    // Burst pulses since the last start; cleared while a start is asked,
    // so a burst that begins early can only under-count, never over-count.
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            pulse_cnt_reg <= 5'h00;
            dclk_prev_reg <= 1'b0;
        end else begin
            dclk_prev_reg <= clk_dev_out;
            if (!chip_select_n && !read_not_convert) pulse_cnt_reg <= 5'h00;
            else if (clk_dev_out && !dclk_prev_reg) pulse_cnt_reg <= pulse_cnt_reg + 5'h01;
        end
    end

    // ========================================================================
    // Assertions
    a_parallel_oe_on: assert property (
        (!chip_select_n && read_not_convert)[*6] |-> parallel_oe)
        else $error("parallel enable low while selected for reading");
    a_parallel_oe_off: assert property (
        (chip_select_n || !read_not_convert)[*6] |-> !parallel_oe)
        else $error("parallel enable high while not reading");
    a_busy_follows_start: assert property (
        $fell(read_not_convert) && !chip_select_n && busy_n |-> ##[1:4] !busy_n)
        else $error("busy did not fall after a start");
    a_busy_low_span: assert property (
        $rose(busy_n) |-> low_cnt_reg >= 16'(CONV_CYCLES) && low_cnt_reg <= 16'(CONV_CYCLES + 2))
        else $error("busy phase length off");
    a_ext_clock_no_start: assert property (
        read_not_convert[*6] |-> !$fell(busy_n))
        else $error("conversion began without a start request");
    a_burst_pulse_count: assert property (
        pulse_cnt_reg <= 5'd16)
        else $error("more than sixteen burst pulses");
    a_burst_half_period: assert property (
        clk_dev_oe && $fell(clk_dev_out) |-> hi_cnt_reg == 8'(INT_HALF_CYC))
        else $error("burst clock high phase length off");
    a_burst_data_stable: assert property (
        clk_dev_oe && clk_dev_out && $past(clk_dev_out) |-> $stable(serial_out_line))
        else $error("serial data moved while burst clock high");
    a_ext_clock_quiet: assert property (
        clock_source_select && !busy_n |-> !$rose(serial_bit_clock))
        else $error("external clock toggled during conversion");

    // Main scenarios reached.
    c_busy_done: cover property ($rose(busy_n));
    c_full_burst: cover property (clk_dev_oe && pulse_cnt_reg == 5'd16);
    c_ext_read: cover property (clock_source_select && $fell(serial_bit_clock));
endmodule

/* testbench/testbench.sv */
/*
 * Self-checking bench joining the converter end to the host end.
 * Assumes the conversion outlasts the burst clock, as the device demands.
 */
module testbench
    import saosp_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    // ========================================================================
    // Signals
    localparam int CONV_N   = 2000;
    localparam int LOAD_N   = 1200;
    localparam int WAIT_MAX = 6000;
    logic                       clk, rst_n, ext_mode, chain_bit;
    logic                       start, start_ready, word_valid, word_ready;
    logic [RESULT_W-1:0]        word_data, last_result;
    logic signed [RESULT_W+1:0] sample_in;
    logic [RESULT_W-1:0]        exp_q[$];
    int                         mismatches, checks;

    saosp_if i_saosp_if ();
    saosp_device #(.CONV_CYCLES(CONV_N), .LOAD_CYCLES(LOAD_N)) i_saosp_device (
        .CLK(clk), .RST_N(rst_n), .CE(1'b1), .PINS(i_saosp_if.device),
        .SAMPLE_IN(sample_in), .LAST_RESULT(last_result));
    saosp_host i_saosp_host (
        .CLK(clk), .RST_N(rst_n), .CE(1'b1), .PINS(i_saosp_if.host),
        .EXT_MODE(ext_mode), .CHAIN_BIT(chain_bit), .START(start),
        .START_READY(start_ready), .WORD_VALID(word_valid),
        .WORD_READY(word_ready), .WORD_DATA(word_data));
    saosp_assertions #(.CONV_CYCLES(CONV_N)) i_saosp_assertions (
        .CLK(clk), .RST_N(rst_n),
        .chip_select_n(i_saosp_if.chip_select_n),
        .read_not_convert(i_saosp_if.read_not_convert),
        .clock_source_select(i_saosp_if.clock_source_select),
        .busy_n(i_saosp_if.busy_n), .serial_out_line(i_saosp_if.serial_out_line),
        .clk_dev_out(i_saosp_if.clk_dev_out), .clk_dev_oe(i_saosp_if.clk_dev_oe),
        .parallel_oe(i_saosp_if.parallel_oe),
        .serial_bit_clock(i_saosp_if.serial_bit_clock));

    // 100 MHz system clock.
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    // ========================================================================
    // Reporting
    task automatic conclude();
        $display("checks %0d mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    task automatic give_up(input string what);
        mismatches++;
        $display("[ERR] %s expected event seen timeout", what);
        conclude();
    endtask

    task automatic cmp_word(input string what, input logic [15:0] exp, input logic [15:0] got);
        checks++;
        if (got !== exp) begin
            mismatches++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic cmp_bit(input string what, input logic exp, input logic got);
        checks++;
        if (got !== exp) begin
            mismatches++;
            $display("[ERR] %s expected %b seen %b", what, exp, got);
        end
    endtask

    // ========================================================================
    // Helpers
    // Expected code: clamp to full scale, never wrap.
    function automatic logic [15:0] clip(input int s);
        if (s > 32767) return CODE_POS_FS;
        if (s < -32768) return CODE_NEG_FS;
        return 16'(s);
    endfunction

    // Exact boundaries first, then a sweep across the stand-in's range.
    function automatic int sample_of(input int i);
        case (i)
            0: return 32767;
            1: return -32768;
            2: return 32768;
            3: return -32769;
            default: return i * 8000 - 128000;
        endcase
    endfunction

    task automatic wait_high(input string what, ref logic sig);
        for (int n = 0; n < WAIT_MAX; n++) begin
            @(negedge clk);
            if (sig === 1'b1) return;
        end
        give_up(what);
    endtask

    // Burst data moves on its falling edge, so it is taken at the rise; data
    // under the host clock moves after a rise, so it is taken at the fall.
    task automatic wait_bclk(input logic to);
        logic prev;
        prev = i_saosp_if.serial_bit_clock;
        for (int n = 0; n < WAIT_MAX; n++) begin
            @(negedge clk);
            if (prev === !to && i_saosp_if.serial_bit_clock === to) return;
            prev = i_saosp_if.serial_bit_clock;
        end
        give_up("link clock edge");
    endtask

    task automatic collect(input logic on_rise, output logic [15:0] word);
        word = 16'h0000;
        for (int k = 0; k < RESULT_W; k++) begin
            wait_bclk(on_rise);
            word = {word[14:0], i_saosp_if.serial_out_line};
        end
    endtask

    task automatic do_start();
        wait_high("start ready", start_ready);
        start = 1'b1;
        @(negedge clk);
        start = 1'b0;
    endtask

    // ========================================================================
    // Scenarios
    // Burst clock carries the previous result, then parks low on the chain bit.
    task automatic t_internal(input int s, input logic chain, input logic [15:0] prev);
        logic [15:0] got;
        ext_mode = 1'b0;
        chain_bit = chain;
        sample_in = 18'(s);
        do_start();
        collect(1'b1, got);
        cmp_word("burst word", prev, got);
        repeat (100) @(negedge clk);
        cmp_bit("link clock after burst", 1'b0, i_saosp_if.serial_bit_clock);
        cmp_bit("level after burst", chain, i_saosp_if.serial_out_line);
        repeat (300) @(negedge clk);
        cmp_word("last result", clip(s), last_result);
    endtask

    // Back-to-back external reads fill the buffer until it refuses, then drain.
    task automatic t_ext_fill();
        logic [15:0] got;
        ext_mode = 1'b1;
        word_ready = 1'b0;
        for (int i = 0; i < 32; i++) begin
            sample_in = 18'(sample_of(i));
            exp_q.push_back(clip(sample_of(i)));
            do_start();
            collect(1'b0, got);
            cmp_word("external link word", exp_q[i], got);
            repeat (60) @(negedge clk);
        end
        cmp_bit("start ready when full", 1'b0, start_ready);
        for (int i = 0; i < 32; i++) begin
            wait_high("word valid", word_valid);
            cmp_word("buffered word", exp_q[i], word_data);
            word_ready = 1'b1;
            @(negedge clk);
            word_ready = 1'b0;
        end
        @(negedge clk);
        cmp_bit("buffer empty", 1'b0, word_valid);
    endtask

    // ========================================================================
    // Main sequence
    initial begin
        rst_n = 1'b0;
        ext_mode = 1'b0;
        chain_bit = 1'b0;
        start = 1'b0;
        word_ready = 1'b0;
        sample_in = '0;
        mismatches = 0;
        checks = 0;
        repeat (5) @(negedge clk);
        rst_n = 1'b1;
        repeat (8) @(negedge clk);
        cmp_bit("parallel enable idle", 1'b1, i_saosp_if.parallel_oe);
        t_internal(1, 1'b1, RESULT_RST);
        t_internal(-5, 1'b0, 16'h0001);
        t_ext_fill();
        conclude();
    end
endmodule
